/* hdl/icc_defs.vh */
// Register map, field positions and bus codes of the condition controller.
`ifndef ICC_DEFS_VH
`define ICC_DEFS_VH

// Channel count and address geometry.
`define ICC_NCH         6
`define ICC_AW          12
`define ICC_IDX_W       10
`define ICC_IDX_HI      11
`define ICC_IDX_LO      2

// Register indices; byte address is four times the index.
`define ICC_SMR4_IDX    {10'h2a4, 10'h294, 10'h284, 10'h264, 10'h254, 10'h244}
`define ICC_SMR3_IDX    {10'h2a5, 10'h295, 10'h285, 10'h265, 10'h255, 10'h245}

// Condition control register fields.
`define ICC_B_START     0
`define ICC_B_RSTART    1
`define ICC_B_STOP      2
`define ICC_B_SEL       3
`define ICC_B_ACK_LEVEL_VALUE      4
`define ICC_B_ACK_OUTPUT_SELECT      5
`define ICC_B_REL       6
`define ICC_B_HOLD      7
`define ICC_SMR4_RST    8'h00

// Clock phase and delay control register fields.
`define ICC_B_CLOCK_PHASE_DELAY_SEL      1
`define ICC_B_CLOCK_PIN_OPEN_DRAIN_SEL      3
`define ICC_DL_HI       7
`define ICC_DL_LO       5
`define ICC_DL_W        3
`define ICC_DLY_N       8
`define ICC_SMR3_MASK   8'hea
`define ICC_SMR3_RST    8'h00

// Register and bus widths, and bus response codes.
`define ICC_RW          8
`define ICC_DW          32
`define ICC_SW          4
`define ICC_RESP_OKAY   2'b00
`define ICC_RESP_SLVERR 2'b10

`endif

/* hdl/icc_ctrl.v */
// Two-wire condition generator, line control and data delay, six channels.
//
// Contract
// - Phase bit set delays serial clock phase
// - Open-drain bit: clock pin never driven high
// - Data line delayed digitally by 3-bit field
// - Field N gives N to N+1 divider ticks
// - Unimplemented bits read undefined, write zero
// - Start request bit self-clears after start
// - Restart request bit self-clears after restart
// - Stop request bit self-clears after stop
// - Output select drives conditions onto lines
// - Ack select drives ack value on data
// - Clock output stop enable releases clock line
// - Clock hold bit holds clock line low
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "icc_defs.vh"

module icc_ctrl (
    // Clock and reset.
    input  wire                        aclk,
    input  wire                        aresetn,
    // AXI4-Lite write address channel.
    input  wire [`ICC_AW-1:0]          s_axi_awaddr,
    input  wire [2:0]                  s_axi_awprot,
    input  wire                        s_axi_awvalid,
    output wire                        s_axi_awready,
    // AXI4-Lite write data channel.
    input  wire [`ICC_DW-1:0]          s_axi_wdata,
    input  wire [`ICC_SW-1:0]          s_axi_wstrb,
    input  wire                        s_axi_wvalid,
    output wire                        s_axi_wready,
    // AXI4-Lite write response channel.
    output wire [1:0]                  s_axi_bresp,
    output wire                        s_axi_bvalid,
    input  wire                        s_axi_bready,
    // AXI4-Lite read address channel.
    input  wire [`ICC_AW-1:0]          s_axi_araddr,
    input  wire [2:0]                  s_axi_arprot,
    input  wire                        s_axi_arvalid,
    output wire                        s_axi_arready,
    // AXI4-Lite read data channel.
    output wire [`ICC_DW-1:0]          s_axi_rdata,
    output wire [1:0]                  s_axi_rresp,
    output wire                        s_axi_rvalid,
    input  wire                        s_axi_rready,
    // Per-channel serial logic side.
    input  wire [`ICC_NCH-1:0]         brg_tick,
    input  wire [`ICC_NCH-1:0]         ser_scl,
    input  wire [`ICC_NCH-1:0]         ser_sda,
    // Per-channel line drivers.
    output wire [`ICC_NCH-1:0]         scl_out,
    output wire [`ICC_NCH-1:0]         scl_oe,
    output wire [`ICC_NCH-1:0]         sda_out,
    output wire [`ICC_NCH-1:0]         sda_oe
);

    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_START  = 2'h1;
    localparam [1:0] ST_RSTART = 2'h2;
    localparam [1:0] ST_STOP   = 2'h3;
    localparam [1:0] STEP0     = 2'h0;
    localparam [1:0] STEP1     = 2'h1;
    localparam [1:0] STEP2     = 2'h2;
    localparam [1:0] STEP3     = 2'h3;

    localparam [`ICC_NCH*`ICC_IDX_W-1:0] SMR4_IDX = `ICC_SMR4_IDX;
    localparam [`ICC_NCH*`ICC_IDX_W-1:0] SMR3_IDX = `ICC_SMR3_IDX;

    // Bus slave state.
    reg                          awready_reg;
    reg                          wready_reg;
    reg                          aw_held_reg;
    reg                          w_held_reg;
    reg  [`ICC_IDX_W-1:0]        aw_idx_reg;
    reg  [`ICC_RW-1:0]           wdata_reg;
    reg                          wstrb0_reg;
    reg                          bvalid_reg;
    reg  [1:0]                   bresp_reg;
    reg                          arready_reg;
    reg                          rvalid_reg;
    reg  [`ICC_DW-1:0]           rdata_reg;
    reg  [1:0]                   rresp_reg;
    reg  [`ICC_NCH-1:0]          sda_out_reg;

    wire [`ICC_NCH*`ICC_RW-1:0]  smr4_all;
    wire [`ICC_NCH*`ICC_RW-1:0]  smr3_all;
    wire [`ICC_IDX_W-1:0]        ar_idx;
    wire                         wr_do;

    reg  [`ICC_DW-1:0]           rd_data;
    reg                          rd_hit;
    reg                          wr_hit;
    integer                      i;

    assign ar_idx = s_axi_araddr[`ICC_IDX_HI:`ICC_IDX_LO];
    assign wr_do  = aw_held_reg & w_held_reg & ~bvalid_reg;

    assign s_axi_awready = awready_reg;
    assign s_axi_wready  = wready_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign sda_out       = sda_out_reg;

    // Address decode; reserved bits of a mapped register read as zero.
    always @* begin
        rd_data = {`ICC_DW{1'b0}};
        rd_hit  = 1'b0;
        wr_hit  = 1'b0;
        for (i = 0; i < `ICC_NCH; i = i + 1) begin
            if (ar_idx == SMR4_IDX[i*`ICC_IDX_W +: `ICC_IDX_W]) begin
                rd_data[`ICC_RW-1:0] = smr4_all[i*`ICC_RW +: `ICC_RW];
                rd_hit = 1'b1;
            end else if (ar_idx == SMR3_IDX[i*`ICC_IDX_W +: `ICC_IDX_W]) begin
                rd_data[`ICC_RW-1:0] = smr3_all[i*`ICC_RW +: `ICC_RW];
                rd_hit = 1'b1;
            end
            if (aw_idx_reg == SMR4_IDX[i*`ICC_IDX_W +: `ICC_IDX_W] ||
                aw_idx_reg == SMR3_IDX[i*`ICC_IDX_W +: `ICC_IDX_W])
                wr_hit = 1'b1;
        end
    end

    // Take write address and data in either order, then answer.
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b0;
            wready_reg  <= 1'b0;
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_idx_reg  <= {`ICC_IDX_W{1'b0}};
            wdata_reg   <= {`ICC_RW{1'b0}};
            wstrb0_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= `ICC_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_held_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_idx_reg  <= s_axi_awaddr[`ICC_IDX_HI:`ICC_IDX_LO];
            end else if (!aw_held_reg) begin
                awready_reg <= 1'b1;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_held_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg  <= s_axi_wdata[`ICC_RW-1:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end else if (!w_held_reg) begin
                wready_reg <= 1'b1;
            end
            if (wr_do) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wr_hit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
            end else if (bvalid_reg && s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Read address is answered on the next edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= {`ICC_DW{1'b0}};
            rresp_reg   <= `ICC_RESP_OKAY;
            sda_out_reg <= {`ICC_NCH{1'b0}};
        end else begin
            sda_out_reg <= {`ICC_NCH{1'b0}};
            if (s_axi_arvalid && arready_reg) begin
                arready_reg <= 1'b0;
                rvalid_reg  <= 1'b1;
                rdata_reg   <= rd_data;
                rresp_reg   <= rd_hit ? `ICC_RESP_OKAY : `ICC_RESP_SLVERR;
            end else if (!rvalid_reg || s_axi_rready) begin
                rvalid_reg  <= 1'b0;
                arready_reg <= 1'b1;
            end
        end
    end

    genvar c;
    generate
        for (c = 0; c < `ICC_NCH; c = c + 1) begin : gen_ch
            reg  [`ICC_RW-1:0]    smr4_reg;
            reg  [`ICC_RW-1:0]    smr3_reg;
            reg  [1:0]            cg_state_reg;
            reg  [1:0]            cg_step_reg;
            reg                   cg_scl_reg;
            reg                   cg_sda_reg;
            reg  [`ICC_DLY_N-1:0] dly_reg;
            reg                   clock_phase_delay_sel_reg;
            reg                   scl_out_reg;
            reg                   scl_oe_reg;
            reg                   sda_oe_reg;

            wire                  smr4_wr;
            wire                  smr3_wr;
            wire                  sel;
            wire                  done_start;
            wire                  done_rstart;
            wire                  done_stop;
            wire [`ICC_DL_W-1:0]  dl;
            wire                  sda_src;
            wire                  sda_dly;
            wire                  scl_src;
            wire                  scl_lvl;
            wire                  sda_lvl;

            assign smr4_wr = wr_do & wstrb0_reg &
                (aw_idx_reg == SMR4_IDX[c*`ICC_IDX_W +: `ICC_IDX_W]);
            assign smr3_wr = wr_do & wstrb0_reg &
                (aw_idx_reg == SMR3_IDX[c*`ICC_IDX_W +: `ICC_IDX_W]);
            assign sel = smr4_reg[`ICC_B_SEL];

            assign done_start  = brg_tick[c] & (cg_state_reg == ST_START) &
                                 (cg_step_reg == STEP2);
            assign done_rstart = brg_tick[c] & (cg_state_reg == ST_RSTART) &
                                 (cg_step_reg == STEP3);
            assign done_stop   = brg_tick[c] & (cg_state_reg == ST_STOP) &
                                 (cg_step_reg == STEP2);

            // Ack value replaces serial data when ack output is selected.
            assign sda_src = smr4_reg[`ICC_B_ACK_OUTPUT_SELECT] ?
                             smr4_reg[`ICC_B_ACK_LEVEL_VALUE] : ser_sda[c];
            assign dl      = smr3_reg[`ICC_DL_HI:`ICC_DL_LO];
            assign sda_dly = (dl == {`ICC_DL_W{1'b0}}) ?
                             sda_src : dly_reg[dl];
            assign scl_src = smr3_reg[`ICC_B_CLOCK_PHASE_DELAY_SEL] ?
                             clock_phase_delay_sel_reg : ser_scl[c];
            assign scl_lvl = sel ? cg_scl_reg : scl_src;
            assign sda_lvl = sel ? cg_sda_reg : sda_dly;

            assign smr4_all[c*`ICC_RW +: `ICC_RW] = smr4_reg;
            assign smr3_all[c*`ICC_RW +: `ICC_RW] = smr3_reg;
            assign scl_out[c] = scl_out_reg;
            assign scl_oe[c]  = scl_oe_reg;
            assign sda_oe[c]  = sda_oe_reg;

            // A software write in the completion cycle wins over the clear.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    smr4_reg <= `ICC_SMR4_RST;
                    smr3_reg <= `ICC_SMR3_RST;
                end else begin
                    if (smr4_wr) begin
                        smr4_reg <= wdata_reg;
                    end else begin
                        if (done_start)
                            smr4_reg[`ICC_B_START] <= 1'b0;
                        if (done_rstart)
                            smr4_reg[`ICC_B_RSTART] <= 1'b0;
                        if (done_stop)
                            smr4_reg[`ICC_B_STOP] <= 1'b0;
                    end
                    if (smr3_wr)
                        smr3_reg <= wdata_reg & `ICC_SMR3_MASK;
                end
            end

            // Condition generator, one step per divider tick; a first step can change both lines.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    cg_state_reg <= ST_IDLE;
                    cg_step_reg  <= STEP0;
                    cg_scl_reg   <= 1'b1;
                    cg_sda_reg   <= 1'b1;
                end else begin
                    case (cg_state_reg)
                        ST_IDLE: begin
                            cg_step_reg <= STEP0;
                            if (sel && smr4_reg[`ICC_B_START])
                                cg_state_reg <= ST_START;
                            else if (sel && smr4_reg[`ICC_B_RSTART])
                                cg_state_reg <= ST_RSTART;
                            else if (sel && smr4_reg[`ICC_B_STOP])
                                cg_state_reg <= ST_STOP;
                        end
                        default: begin
                            if (brg_tick[c]) begin
                                cg_step_reg <= cg_step_reg + STEP1;
                                case ({cg_state_reg, cg_step_reg})
                                    {ST_START, STEP0}: begin
                                        cg_scl_reg <= 1'b1;
                                        cg_sda_reg <= 1'b1;
                                    end
                                    {ST_START, STEP1}: cg_sda_reg <= 1'b0;
                                    {ST_START, STEP2}: begin
                                        cg_scl_reg   <= 1'b0;
                                        cg_state_reg <= ST_IDLE;
                                    end
                                    {ST_RSTART, STEP0}: begin
                                        cg_scl_reg <= 1'b0;
                                        cg_sda_reg <= 1'b1;
                                    end
                                    {ST_RSTART, STEP1}: cg_scl_reg <= 1'b1;
                                    {ST_RSTART, STEP2}: cg_sda_reg <= 1'b0;
                                    {ST_RSTART, STEP3}: begin
                                        cg_scl_reg   <= 1'b0;
                                        cg_state_reg <= ST_IDLE;
                                    end
                                    {ST_STOP, STEP0}: begin
                                        cg_scl_reg <= 1'b0;
                                        cg_sda_reg <= 1'b0;
                                    end
                                    {ST_STOP, STEP1}: cg_scl_reg <= 1'b1;
                                    {ST_STOP, STEP2}: begin
                                        cg_sda_reg   <= 1'b1;
                                        cg_state_reg <= ST_IDLE;
                                    end
                                    default: cg_state_reg <= ST_IDLE;
                                endcase
                            end
                        end
                    endcase
                end
            end

            // Data delay line and clock phase stage, on divider ticks.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    dly_reg  <= {`ICC_DLY_N{1'b1}};
                    clock_phase_delay_sel_reg <= 1'b1;
                end else if (brg_tick[c]) begin
                    dly_reg  <= {dly_reg[`ICC_DLY_N-2:0], sda_src};
                    clock_phase_delay_sel_reg <= ser_scl[c];
                end
            end

            // Line drivers; low hold has priority over release.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    scl_out_reg <= 1'b0;
                    scl_oe_reg  <= 1'b0;
                    sda_oe_reg  <= 1'b0;
                end else begin
                    if (smr4_reg[`ICC_B_HOLD]) begin
                        scl_out_reg <= 1'b0;
                        scl_oe_reg  <= 1'b1;
                    end else if (smr4_reg[`ICC_B_REL]) begin
                        scl_out_reg <= 1'b0;
                        scl_oe_reg  <= 1'b0;
                    end else if (smr3_reg[`ICC_B_CLOCK_PIN_OPEN_DRAIN_SEL]) begin
                        scl_out_reg <= 1'b0;
                        scl_oe_reg  <= ~scl_lvl;
                    end else begin
                        scl_out_reg <= scl_lvl;
                        scl_oe_reg  <= 1'b1;
                    end
                    sda_oe_reg <= ~sda_lvl;
                end
            end
        end
    endgenerate

endmodule // icc_ctrl

/* tb/icc_bus_model.sv */
// Two-wire bus model: pull-ups, wired-low lines and clock stretching.
`timescale 1ns/1ps
`include "icc_defs.vh"
module icc_bus_model (
    // Device line drivers.
    input  wire [`ICC_NCH-1:0] scl_out,
    input  wire [`ICC_NCH-1:0] scl_oe,
    input  wire [`ICC_NCH-1:0] sda_out,
    input  wire [`ICC_NCH-1:0] sda_oe,
    // Far-side device holding the clock low.
    input  wire [`ICC_NCH-1:0] stretch,
    // Resolved line levels.
    output wire [`ICC_NCH-1:0] scl_wire,
    output wire [`ICC_NCH-1:0] sda_wire
);
    // Released lines float up; a low driver wins.
    assign scl_wire = ~((scl_oe & ~scl_out) | stretch);
    assign sda_wire = ~(sda_oe & ~sda_out);
endmodule // icc_bus_model

/* tb/icc_ctrl_properties.sv */
// Port checker bound to the condition controller.
`timescale 1ns/1ps
`include "icc_defs.vh"
module icc_ctrl_properties (
    // Clock, reset and bus.
    input wire               aclk,
    input wire               aresetn,
    input wire [`ICC_AW-1:0] s_axi_awaddr,
    input wire               s_axi_awvalid,
    input wire               s_axi_awready,
    input wire [`ICC_DW-1:0] s_axi_wdata,
    input wire               s_axi_wvalid,
    input wire               s_axi_wready,
    input wire               s_axi_bvalid,
    input wire               s_axi_bready,
    input wire               s_axi_arvalid,
    input wire               s_axi_arready,
    input wire [`ICC_DW-1:0] s_axi_rdata,
    input wire               s_axi_rvalid,
    input wire               s_axi_rready,
    // Line side.
    input wire [`ICC_NCH-1:0] brg_tick,
    input wire [`ICC_NCH-1:0] ser_scl,
    input wire [`ICC_NCH-1:0] scl_out,
    input wire [`ICC_NCH-1:0] scl_oe,
    input wire [`ICC_NCH-1:0] sda_out,
    input wire [`ICC_NCH-1:0] sda_oe
);
    reg [11:0] pa_reg;
    reg [7:0]  pd_reg;
    reg        bv_reg;
    reg [7:0]  c4_reg;
    reg [7:0]  c3_reg;
    reg [1:0]  q_reg;
    wire       quiet = q_reg == 2'd3;
    wire       plain = quiet && (c4_reg & 8'hc8) == 0 && (c3_reg & 8'h0a) == 0;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Shadow of channel 0 settings; quiet marks settled outputs.
    always @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready)
            pa_reg <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            pd_reg <= s_axi_wdata[7:0];
        if (!aresetn) begin
            bv_reg <= 1'b0;
            c4_reg <= 8'h00;
            c3_reg <= 8'h00;
            q_reg  <= 2'd0;
        end else begin
            bv_reg <= s_axi_bvalid;
            if (s_axi_bvalid && !bv_reg && pa_reg == 12'h910)
                c4_reg <= pd_reg;
            if (s_axi_bvalid && !bv_reg && pa_reg == 12'h914)
                c3_reg <= pd_reg;
            if (s_axi_bvalid && !bv_reg)
                q_reg <= 2'd0;
            else if (!quiet)
                q_reg <= q_reg + 2'd1;
        end
    end
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write not answered");
    chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid) else $error("bvalid dropped");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid[*1]) else $error("read not answered");
    chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read moved");
    chk_upper_zero: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 0) else $error("upper bits set");
    chk_hold_low: assert property (quiet && c4_reg[7] |->
        !scl_out[0] && scl_oe[0]) else $error("clock not held low");
    chk_release_clk: assert property (quiet && c4_reg[7:6] == 2'b01
        |-> !scl_oe[0]) else $error("clock not released");
    chk_never_high: assert property (quiet && c3_reg[3] &&
        c4_reg[7:6] == 0 |-> !(scl_oe[0] && scl_out[0]))
        else $error("clock driven high");
    chk_ack_drive: assert property (quiet && c4_reg[5] && !c4_reg[3] &&
        c3_reg[7:5] == 0 |-> sda_oe[0] == !c4_reg[4])
        else $error("ack level wrong");
    chk_clk_follow: assert property (plain |-> scl_oe[0] &&
        scl_out[0] == $past(ser_scl[0])) else $error("clock not passed");
    chk_phase_wait: assert property (quiet && c3_reg[3:1] == 3'b001 &&
        (c4_reg & 8'hc8) == 0 && !$past(brg_tick[0]) &&
        !$past(brg_tick[0], 2) && !$past(brg_tick[0], 3)
        |-> $stable(scl_out[0])) else $error("clock moved");
    chk_sda_no_high: assert property (sda_out == 0)
        else $error("data driven high");
    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_hold: cover property (quiet && c4_reg[7]);
    cov_phase: cover property (quiet && c3_reg[1] && brg_tick[0]);
endmodule // icc_ctrl_properties
bind icc_ctrl icc_ctrl_properties u_props (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .brg_tick(brg_tick), .ser_scl(ser_scl), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

/* tb/test_i2c_condition_and_delay_control.sv */
// Self-checking bench for the condition controller.
`timescale 1ns/1ps
`include "icc_defs.vh"
module test_i2c_condition_and_delay_control;
    localparam [71:0] CA = 72'ha90a50a10990950910;
    localparam [63:0] T4 = 64'h3020000000c04080;
    localparam [63:0] T3 = 64'h0000080808000000;
    localparam [23:0] TI = 24'h9b8d96;
    localparam [23:0] TE = 24'hf8c75d;
    reg         aclk, aresetn, aw_v, w_v, ar_v;
    reg  [11:0] aw_a, ar_a;
    reg  [31:0] w_d, d;
    reg  [5:0]  tick, s_scl, s_sda, strch;
    wire        aw_r, w_r, b_v, ar_r, r_v;
    wire [1:0]  b_resp, r_resp;
    wire [31:0] r_d;
    wire [5:0]  scl_o, scl_e, sda_o, sda_e, scl_w, sda_w;
    integer     n_errors, check_count, i, k, n;
    icc_ctrl uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
        .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hf), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(1'b1), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
        .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(1'b1),
        .brg_tick(tick), .ser_scl(s_scl), .ser_sda(s_sda), .scl_out(scl_o),
        .scl_oe(scl_e), .sda_out(sda_o), .sda_oe(sda_e));
    icc_bus_model bus (.scl_out(scl_o), .scl_oe(scl_e), .sda_out(sda_o),
        .sda_oe(sda_e), .stretch(strch), .scl_wire(scl_w), .sda_wire(sda_w));
    task cmp(input [31:0] g, input [31:0] e);
        begin
            check_count = check_count + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, g, e);
            end
        end
    endtask
    task tally_and_finish;
        begin
            $display("errors=%0d checks=%0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // Address and data go together; each drops when taken.
    task wr(input [11:0] a, input [7:0] v, input [1:0] er);
        reg ad, wd, bd;
        integer t;
        begin
            {ad, wd, bd} = 3'b000;
            aw_a <= a;
            w_d <= {24'h0, v};
            aw_v <= 1'b1;
            w_v <= 1'b1;
            for (t = 0; t < 50 && !bd; t = t + 1) begin
                @(posedge aclk);
                if (b_v === 1'b1) begin
                    bd = 1;
                    cmp(b_resp, er);
                end
                if (aw_r === 1'b1 && !ad) begin
                    ad = 1;
                    aw_v <= 1'b0;
                end
                if (w_r === 1'b1 && !wd) begin
                    wd = 1;
                    w_v <= 1'b0;
                end
            end
            if (!bd) begin
                n_errors = n_errors + 1;
                tally_and_finish;
            end
        end
    endtask
    task rd(input [11:0] a, input [1:0] er);
        reg ak, dn;
        integer t;
        begin
            {ak, dn} = 2'b00;
            ar_a <= a;
            ar_v <= 1'b1;
            for (t = 0; t < 50 && !dn; t = t + 1) begin
                @(posedge aclk);
                if (ar_r === 1'b1 && !ak) begin
                    ak = 1;
                    ar_v <= 1'b0;
                end
                if (r_v === 1'b1) begin
                    dn = 1;
                    d = r_d;
                    cmp(r_resp, er);
                end
            end
            if (!dn) begin
                n_errors = n_errors + 1;
                tally_and_finish;
            end
        end
    endtask
    task tk(input integer m);
        repeat (m) begin
            @(posedge aclk) tick <= 6'h3f;
            @(posedge aclk) tick <= 6'h00;
        end
    endtask
    task sv;
        repeat (3) @(posedge aclk);
    endtask
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, aw_v, w_v, ar_v, aw_a, ar_a, w_d, tick, strch} = 0;
        s_scl = 6'h3f;
        s_sda = 6'h3f;
        n_errors = 0;
        check_count = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        for (i = 0; i < 6; i = i + 1) begin
            rd(CA[12*i+:12], 2'b00);
            cmp(d, 32'h0);
            rd(CA[12*i+:12] + 12'h004, 2'b00);
            cmp(d, 32'h0);
            wr(CA[12*i+:12], 8'hf8, 2'b00);
            rd(CA[12*i+:12], 2'b00);
            cmp(d, 32'hf8);
            wr(CA[12*i+:12], 8'h00, 2'b00);
        end
        rd(12'h000, 2'b10);
        wr(12'h000, 8'h55, 2'b10);
        wr(12'h914, 8'hff, 2'b00);
        rd(12'h914, 2'b00);
        cmp(d, 32'hea);
        for (i = 0; i < 8; i = i + 1) begin
            wr(12'h910, T4[8*i+:8], 2'b00);
            wr(12'h914, T3[8*i+:8], 2'b00);
            {s_scl[0], s_sda[0], strch[0]} <= TI[3*i+:3];
            sv;
            cmp({scl_e[0], scl_w[0], sda_w[0]}, TE[3*i+:3]);
        end
        wr(12'h910, 8'h00, 2'b00);
        s_sda[0] <= 1'b1;
        for (k = 0; k < 3; k = k + 1) begin
            d = 32'h7;
            wr(12'h910, 8'h01 << k, 2'b00);
            wr(12'h910, (8'h01 << k) | 8'h08, 2'b00);
            for (n = 1; n < 8 && d[k] !== 1'b0; n = n + 1) begin
                tk(1);
                rd(12'h910, 2'b00);
            end
            cmp(n >= 3 && n <= k + 4 - 2 * (k / 2), 1);
            cmp(d, 32'h08);
            sv;
            cmp({scl_w[0], sda_w[0]}, (k == 2) ? 2'b11 : 2'b00);
        end
        wr(12'h910, 8'h01, 2'b00);
        tk(5);
        rd(12'h910, 2'b00);
        cmp(d, 32'h01);
        wr(12'h910, 8'h00, 2'b00);
        for (k = 0; k < 8; k = k + 1) begin
            wr(12'h914, k << 5, 2'b00);
            tk(9);
            s_sda[0] <= 1'b0;
            sv;
            for (n = 0; n < 10 && sda_w[0] !== 1'b0; n = n + 1) begin
                tk(1);
                sv;
            end
            cmp(n >= k && n <= k + (k > 0), 1);
            s_sda[0] <= 1'b1;
        end
        wr(12'h914, 8'h02, 2'b00);
        tk(2);
        s_scl[0] <= 1'b0;
        sv;
        cmp(scl_w[0], 1'b1);
        tk(1);
        sv;
        cmp(scl_w[0], 1'b0);
        wr(12'h914, 8'h00, 2'b00);
        tally_and_finish;
    end
endmodule // test_i2c_condition_and_delay_control
